// >>> verilog/wdtc_pkg.sv
// Purpose: Shared constants of the watchdog timer control block
// Assumes: AXI4-Lite register bus, 32-bit data, one SYS_CLK domain
// Notes: Offsets are byte addresses of aligned 32-bit words
package wdtc_pkg;
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam int REG_W = 8;

    // Register byte offsets
    localparam logic [7:0] CTRL_OFF = 8'h00;
    localparam logic [7:0] RSTAT_OFF = 8'h04;
    localparam logic [7:0] RESTART_OFF = 8'h08;
    localparam logic [7:0] ISTAT_OFF = 8'h0c;
    localparam logic [7:0] IMASK_OFF = 8'h10;

    // Control register fields
    localparam int CTRL_TS3 = 5;
    localparam int CTRL_CE = 4;
    localparam int CTRL_EN = 3;
    localparam int CTRL_TS_LO = 0;
    localparam int TS_LO_W = 3;
    localparam int TS_W = 4;

    // Reset cause status fields
    localparam int RSTAT_WDRF = 3;

    // Interrupt status and mask fields
    localparam int IRQ_W = 2;
    localparam int IRQ_TIMEOUT = 0;
    localparam int IRQ_DISABLED = 1;

    // Time-out selection
    localparam logic [3:0] TS_RESET = 4'h0;
    localparam logic [3:0] TS_MAX_LEGAL = 4'h9;
    localparam logic [3:0] TS_FALLBACK = 4'h9;
    localparam int BASE_CYCLES = 2048;

    // Change-enable window length in SYS_CLK cycles
    localparam logic [2:0] CE_CYCLES = 3'h4;

    // Clock rates; the oscillator tick is a divided enable
    localparam int SYS_CLK_HZ = 10_000_000;
    localparam int WDT_OSC_HZ = 128_000;
    localparam int TICK_DIV = SYS_CLK_HZ / WDT_OSC_HZ;

    // Fuse capture delay after reset release
    localparam logic [1:0] CAP_WAIT = 2'h3;

    // Common reset vector
    localparam int VEC_W = 16;
    localparam logic [15:0] RESET_VECTOR = 16'h0000;

    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// >>> verilog/wdtc_axil.sv
// Purpose: AXI4-Lite slave front end of the watchdog control block
// Assumes: One write and one read under way at a time
// Notes: Address and data of a write may arrive in either order
`timescale 1ns/1ps
module wdtc_axil (
    input wire logic clk,
    input wire logic rst,
    input wire logic [7:0] awaddr,
    input wire logic awvalid,
    output logic awready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    input wire logic [7:0] araddr,
    input wire logic arvalid,
    output logic arready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    output logic wr_en,
    output logic [7:0] wr_addr,
    output logic [7:0] wr_data,
    output logic wr_strb0,
    input wire logic wr_hit,
    output logic rd_en,
    output logic [7:0] rd_addr,
    input wire logic [31:0] rd_data,
    input wire logic rd_hit
);
    logic aw_have_q, aw_have_d, w_have_q, w_have_d;
    logic [7:0] aw_addr_q, aw_addr_d, w_data_q, w_data_d;
    logic w_strb_q, w_strb_d;
    logic awready_q, awready_d, wready_q, wready_d;
    logic bvalid_q, bvalid_d, arready_q, arready_d;
    logic rvalid_q, rvalid_d;
    logic [1:0] bresp_q, bresp_d, rresp_q, rresp_d;
    logic [31:0] rdata_q, rdata_d;

    always_comb begin
        aw_have_d = aw_have_q;
        aw_addr_d = aw_addr_q;
        w_have_d = w_have_q;
        w_data_d = w_data_q;
        w_strb_d = w_strb_q;
        bvalid_d = bvalid_q;
        bresp_d = bresp_q;
        wr_en = 1'b0;
        if (awvalid && awready_q) begin
            aw_have_d = 1'b1;
            aw_addr_d = awaddr;
        end
        if (wvalid && wready_q) begin
            w_have_d = 1'b1;
            w_data_d = wdata[7:0];
            w_strb_d = wstrb[0];
        end
        if (aw_have_q && w_have_q && !bvalid_q) begin
            wr_en = 1'b1;
            aw_have_d = 1'b0;
            w_have_d = 1'b0;
            bvalid_d = 1'b1;
            bresp_d = wr_hit ? wdtc_pkg::RESP_OKAY : wdtc_pkg::RESP_SLVERR;
        end
        if (bvalid_q && bready) begin
            bvalid_d = 1'b0;
        end
        awready_d = !aw_have_d && !bvalid_d;
        wready_d = !w_have_d && !bvalid_d;
    end

    always_comb begin
        rvalid_d = rvalid_q;
        rdata_d = rdata_q;
        rresp_d = rresp_q;
        rd_en = arvalid && arready_q;
        if (rd_en) begin
            rvalid_d = 1'b1;
            rdata_d = rd_data;
            rresp_d = rd_hit ? wdtc_pkg::RESP_OKAY : wdtc_pkg::RESP_SLVERR;
        end else if (rvalid_q && rready) begin
            rvalid_d = 1'b0;
        end
        arready_d = !rvalid_d;
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            aw_have_q <= 1'b0;
            aw_addr_q <= 8'h00;
            w_have_q <= 1'b0;
            w_data_q <= 8'h00;
            w_strb_q <= 1'b0;
            awready_q <= 1'b0;
            wready_q <= 1'b0;
            bvalid_q <= 1'b0;
            bresp_q <= 2'h0;
            arready_q <= 1'b0;
            rvalid_q <= 1'b0;
            rdata_q <= 32'h0;
            rresp_q <= 2'h0;
        end else begin
            aw_have_q <= aw_have_d;
            aw_addr_q <= aw_addr_d;
            w_have_q <= w_have_d;
            w_data_q <= w_data_d;
            w_strb_q <= w_strb_d;
            awready_q <= awready_d;
            wready_q <= wready_d;
            bvalid_q <= bvalid_d;
            bresp_q <= bresp_d;
            arready_q <= arready_d;
            rvalid_q <= rvalid_d;
            rdata_q <= rdata_d;
            rresp_q <= rresp_d;
        end
    end

    assign awready = awready_q;
    assign wready = wready_q;
    assign bvalid = bvalid_q;
    assign bresp = bresp_q;
    assign arready = arready_q;
    assign rvalid = rvalid_q;
    assign rdata = rdata_q;
    assign rresp = rresp_q;
    assign wr_addr = aw_addr_q;
    assign wr_data = w_data_q;
    assign wr_strb0 = w_strb_q;
    assign rd_addr = araddr;
endmodule

// >>> verilog/wdtc_top.sv
// Purpose: Watchdog timer control with timed disable and safety levels
// Assumes: Oscillator tick is a divided enable of SYS_CLK
// Notes: Safety level is captured from the fuse after reset release
//
// Notes on behaviour
// - Writing enable one turns watchdog on; zero turns it off if allowed.
// - Enable clears only while the change-enable bit reads one.
// - A zero enable write within four cycles disables; later writes do not.
// - Safety level 2 never disables the watchdog.
// - Safety level 1 forces enable on while the watchdog reset flag is set.
// - Time-out select is four bits: bit 5 and bits 2:0.
// - Codes 0 to 9 give 2048 shifted left by the code ticks.
// - Reserved codes 10 to 15 fall back to a legal selection.
// - Watchdog reset goes to the common reset vector 0x0000.
// - Counter runs on a 128 kHz tick independent of the bus.
// - Change-enable clears by hardware four cycles after being set.
// - Restart, disable and chip reset all clear the counter.
// - Fuse unprogrammed selects level 1, programmed selects level 2.
//
// Local design decisions: register access over AXI4-Lite and the register addresses.
`timescale 1ns/1ps
module wdtc_top #(
    parameter int BASE_CYCLES = wdtc_pkg::BASE_CYCLES,
    parameter int TICK_DIV = wdtc_pkg::TICK_DIV
) (
    input wire logic SYS_CLK,
    input wire logic SYS_RST,
    input wire logic SAFETY_LEVEL_FUSE,
    input wire logic [7:0] AWADDR,
    input wire logic AWVALID,
    output logic AWREADY,
    input wire logic [31:0] WDATA,
    input wire logic [3:0] WSTRB,
    input wire logic WVALID,
    output logic WREADY,
    output logic [1:0] BRESP,
    output logic BVALID,
    input wire logic BREADY,
    input wire logic [7:0] ARADDR,
    input wire logic ARVALID,
    output logic ARREADY,
    output logic [31:0] RDATA,
    output logic [1:0] RRESP,
    output logic RVALID,
    input wire logic RREADY,
    output logic WDT_RESET,
    output logic WDT_IRQ,
    output logic [15:0] RESET_VECTOR
);
    localparam int CW = $clog2(BASE_CYCLES) + 10;
    localparam int DW = $clog2(TICK_DIV + 1);
    localparam logic [DW-1:0] DIV_MAX = DW'(TICK_DIV - 1);

    if (BASE_CYCLES < 1 || CW > 31) begin : g_bad_base
        $error("BASE_CYCLES out of range");
    end
    if (TICK_DIV < 2) begin : g_bad_div
        $error("TICK_DIV must be at least 2");
    end

    logic wr_en, wr_strb0, wr_hit, rd_en, rd_hit;
    logic [7:0] wr_addr, wr_data, rd_addr;
    logic [31:0] rd_data;

    wdtc_axil u_axil (
        .clk(SYS_CLK),
        .rst(SYS_RST),
        .awaddr(AWADDR),
        .awvalid(AWVALID),
        .awready(AWREADY),
        .wdata(WDATA),
        .wstrb(WSTRB),
        .wvalid(WVALID),
        .wready(WREADY),
        .bresp(BRESP),
        .bvalid(BVALID),
        .bready(BREADY),
        .araddr(ARADDR),
        .arvalid(ARVALID),
        .arready(ARREADY),
        .rdata(RDATA),
        .rresp(RRESP),
        .rvalid(RVALID),
        .rready(RREADY),
        .wr_en(wr_en),
        .wr_addr(wr_addr),
        .wr_data(wr_data),
        .wr_strb0(wr_strb0),
        .wr_hit(wr_hit),
        .rd_en(rd_en),
        .rd_addr(rd_addr),
        .rd_data(rd_data),
        .rd_hit(rd_hit)
    );

    // Address decode
    logic wr_ctrl, wr_rstat, wr_restart, wr_imask, rd_istat;
    always_comb begin
        wr_hit = wr_addr inside {wdtc_pkg::CTRL_OFF, wdtc_pkg::RSTAT_OFF,
            wdtc_pkg::RESTART_OFF, wdtc_pkg::ISTAT_OFF, wdtc_pkg::IMASK_OFF};
        rd_hit = rd_addr inside {wdtc_pkg::CTRL_OFF, wdtc_pkg::RSTAT_OFF,
            wdtc_pkg::RESTART_OFF, wdtc_pkg::ISTAT_OFF, wdtc_pkg::IMASK_OFF};
        wr_ctrl = wr_en && wr_strb0 && wr_addr == wdtc_pkg::CTRL_OFF;
        wr_rstat = wr_en && wr_strb0 && wr_addr == wdtc_pkg::RSTAT_OFF;
        wr_restart = wr_en && wr_addr == wdtc_pkg::RESTART_OFF;
        wr_imask = wr_en && wr_strb0 && wr_addr == wdtc_pkg::IMASK_OFF;
        rd_istat = rd_en && rd_addr == wdtc_pkg::ISTAT_OFF;
    end

    // Fuse synchroniser and capture after reset release
    logic fuse_s1_q, fuse_s2_q, lvl2_q, lvl2_d;
    logic [1:0] cap_q, cap_d;
    always_comb begin
        lvl2_d = lvl2_q;
        cap_d = cap_q;
        if (cap_q != wdtc_pkg::CAP_WAIT) begin
            cap_d = cap_q + 2'h1;
            lvl2_d = fuse_s2_q;
        end
    end

    always_ff @(posedge SYS_CLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            fuse_s1_q <= 1'b0;
            fuse_s2_q <= 1'b0;
            lvl2_q <= 1'b0;
            cap_q <= 2'h0;
        end else begin
            fuse_s1_q <= SAFETY_LEVEL_FUSE;
            fuse_s2_q <= fuse_s1_q;
            lvl2_q <= lvl2_d;
            cap_q <= cap_d;
        end
    end

    // Control register and timed sequence
    logic en_q, en_d, wdrf_q, wdrf_d, en_eff, ce_open, dis_ev, expire;
    // Window counter, nonzero while change-enable reads one
    logic [2:0] ce_cnt_q, ce_cnt_d;
    logic [3:0] ts_q, ts_d, wd_ts, ts_use;
    logic wd_en, wd_ce;

    always_comb begin
        ce_open = ce_cnt_q != 3'h0;
        en_eff = lvl2_q || en_q || wdrf_q;
        wd_en = wr_data[wdtc_pkg::CTRL_EN];
        wd_ce = wr_data[wdtc_pkg::CTRL_CE];
        wd_ts = {wr_data[wdtc_pkg::CTRL_TS3],
            wr_data[wdtc_pkg::CTRL_TS_LO +: wdtc_pkg::TS_LO_W]};
        en_d = en_q;
        ts_d = ts_q;
        dis_ev = 1'b0;
        ce_cnt_d = ce_open ? ce_cnt_q - 3'h1 : 3'h0;
        if (wr_ctrl) begin
            if (wd_ce && wd_en) begin
                ce_cnt_d = wdtc_pkg::CE_CYCLES;
            end
            if (wd_en) begin
                en_d = 1'b1;
            end else if (ce_open && !wd_ce && !lvl2_q && !wdrf_q) begin
                en_d = 1'b0;
                dis_ev = en_eff;
            end
            if (!lvl2_q || (ce_open && !wd_ce)) begin
                ts_d = wd_ts;
            end
        end
        wdrf_d = wdrf_q;
        // Expiry wins over a clearing write
        if (wr_rstat && !wr_data[wdtc_pkg::RSTAT_WDRF]) begin
            wdrf_d = 1'b0;
        end
        if (expire) begin
            wdrf_d = 1'b1;
        end
    end

    always_ff @(posedge SYS_CLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            en_q <= 1'b0;
            ts_q <= wdtc_pkg::TS_RESET;
            ce_cnt_q <= 3'h0;
            wdrf_q <= 1'b0;
        end else begin
            en_q <= en_d;
            ts_q <= ts_d;
            ce_cnt_q <= ce_cnt_d;
            wdrf_q <= wdrf_d;
        end
    end

    // Oscillator tick, restart capture and counter
    logic [DW-1:0] div_q, div_d;
    logic [CW-1:0] cnt_q, cnt_d, lim;
    logic tick, rs_pend_q, rs_pend_d;

    always_comb begin
        // Reserved codes run the longest legal time-out
        ts_use = ts_q > wdtc_pkg::TS_MAX_LEGAL ?
            wdtc_pkg::TS_FALLBACK : ts_q;
        lim = CW'(BASE_CYCLES) << ts_use;
        tick = div_q == '0;
        div_d = tick ? DIV_MAX : div_q - DW'(1);
        // Restart held until the next tick consumes it
        rs_pend_d = tick ? wr_restart : rs_pend_q || wr_restart;
        cnt_d = cnt_q;
        expire = 1'b0;
        if (!en_eff) begin
            cnt_d = '0;
        end else if (tick) begin
            if (rs_pend_q) begin
                cnt_d = '0;
            end else if (cnt_q >= lim - CW'(1)) begin
                cnt_d = '0;
                expire = 1'b1;
            end else begin
                cnt_d = cnt_q + CW'(1);
            end
        end
    end

    always_ff @(posedge SYS_CLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            div_q <= '0;
            cnt_q <= '0;
            rs_pend_q <= 1'b0;
        end else begin
            div_q <= div_d;
            cnt_q <= cnt_d;
            rs_pend_q <= rs_pend_d;
        end
    end

    // Interrupt status, mask and outputs
    logic [1:0] istat_q, istat_d, imask_q, imask_d;
    logic irq_q, irq_d, wrst_q;
    logic [15:0] vec_q;

    always_comb begin
        istat_d = istat_q;
        imask_d = imask_q;
        if (rd_istat) begin
            istat_d = 2'h0;
        end
        // Set wins over a clearing read
        istat_d[wdtc_pkg::IRQ_TIMEOUT] =
            istat_d[wdtc_pkg::IRQ_TIMEOUT] || expire;
        istat_d[wdtc_pkg::IRQ_DISABLED] =
            istat_d[wdtc_pkg::IRQ_DISABLED] || dis_ev;
        if (wr_imask) begin
            imask_d = wr_data[wdtc_pkg::IRQ_W-1:0];
        end
        irq_d = |(istat_q & imask_q);
    end

    always_ff @(posedge SYS_CLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            istat_q <= 2'h0;
            imask_q <= 2'h0;
            irq_q <= 1'b0;
            wrst_q <= 1'b0;
            vec_q <= wdtc_pkg::RESET_VECTOR;
        end else begin
            istat_q <= istat_d;
            imask_q <= imask_d;
            irq_q <= irq_d;
            wrst_q <= expire;
            vec_q <= wdtc_pkg::RESET_VECTOR;
        end
    end

    // Read data
    always_comb begin
        rd_data = 32'h0;
        case (rd_addr)
            wdtc_pkg::CTRL_OFF: begin
                rd_data[wdtc_pkg::CTRL_TS3] = ts_q[3];
                rd_data[wdtc_pkg::CTRL_CE] = ce_open;
                rd_data[wdtc_pkg::CTRL_EN] = en_eff;
                rd_data[wdtc_pkg::CTRL_TS_LO +: wdtc_pkg::TS_LO_W] =
                    ts_q[2:0];
            end
            wdtc_pkg::RSTAT_OFF: begin
                rd_data[wdtc_pkg::RSTAT_WDRF] = wdrf_q;
            end
            wdtc_pkg::ISTAT_OFF: begin
                rd_data[wdtc_pkg::IRQ_W-1:0] = istat_q;
            end
            wdtc_pkg::IMASK_OFF: begin
                rd_data[wdtc_pkg::IRQ_W-1:0] = imask_q;
            end
            default: begin
                rd_data = 32'h0;
            end
        endcase
    end

    // Outputs straight from flip-flops
    assign WDT_RESET = wrst_q;
    assign WDT_IRQ = irq_q;
    assign RESET_VECTOR = vec_q;
endmodule

// >>> verif/wdtc_monitor.sv
// Purpose: Port-level checks of the watchdog control block
// Assumes: Single SYS_CLK domain, SYS_RST active high
// Notes: Bound into wdtc_top
`timescale 1ns/1ps
module wdtc_monitor #(
    parameter int BASE_CYCLES = wdtc_pkg::BASE_CYCLES,
    parameter int TICK_DIV = wdtc_pkg::TICK_DIV
) (
    input wire logic SYS_CLK,
    input wire logic SYS_RST,
    input wire logic AWVALID,
    input wire logic AWREADY,
    input wire logic WVALID,
    input wire logic WREADY,
    input wire logic [1:0] BRESP,
    input wire logic BVALID,
    input wire logic BREADY,
    input wire logic ARVALID,
    input wire logic ARREADY,
    input wire logic [31:0] RDATA,
    input wire logic [1:0] RRESP,
    input wire logic RVALID,
    input wire logic RREADY,
    input wire logic WDT_RESET,
    input wire logic WDT_IRQ,
    input wire logic [15:0] RESET_VECTOR
);
    int unsigned gap_q;
    int unsigned gap_d;
    default clocking @(posedge SYS_CLK); endclocking
    default disable iff (SYS_RST);
    // Cycles since the last expiry pulse, saturating
    always_comb begin
        gap_d = WDT_RESET ? 0 : (gap_q < 32'hffff ? gap_q + 1 : gap_q);
    end
    always_ff @(posedge SYS_CLK or posedge SYS_RST) begin
        if (SYS_RST) gap_q <= 32'hffff;
        else gap_q <= gap_d;
    end
    a_vector_zero: assert property (RESET_VECTOR == 16'h0000)
        else $error("reset vector not zero");
    a_expiry_pulse: assert property (WDT_RESET |=> !WDT_RESET)
        else $error("expiry pulse longer than one cycle");
    a_expiry_gap: assert property (WDT_RESET |->
        gap_q >= BASE_CYCLES * TICK_DIV - 1)
        else $error("expiries closer than shortest time-out");
    a_write_resp: assert property (AWVALID && AWREADY && WVALID && WREADY
        |=> !BVALID ##1 BVALID)
        else $error("write response not two edges after accept");
    a_read_resp: assert property (ARVALID && ARREADY |=> RVALID)
        else $error("read data not one edge after accept");
    a_bresp_once: assert property (BVALID && BREADY |=> !BVALID)
        else $error("write response repeated");
    a_rresp_once: assert property (RVALID && RREADY |=> !RVALID)
        else $error("read data repeated");
    a_irq_clear: assert property ($fell(WDT_IRQ) |-> $past(RVALID)
        || $past(RVALID, 2) || $past(RVALID, 3) || $past(BVALID)
        || $past(BVALID, 2) || $past(BVALID, 3))
        else $error("interrupt dropped without bus access");
    a_err_data: assert property (RVALID && RRESP == 2'h2 |-> RDATA == 0)
        else $error("error read returned data");
    a_upper_zero: assert property (RVALID |-> RDATA[31:8] == 24'h0)
        else $error("upper read bits not zero");
    c_expiry: cover property (WDT_RESET);
    c_irq: cover property ($rose(WDT_IRQ));
    c_werr: cover property (BVALID && BRESP == 2'h2);
endmodule
bind wdtc_top wdtc_monitor #(.BASE_CYCLES(BASE_CYCLES),
    .TICK_DIV(TICK_DIV)) u_mon (.SYS_CLK, .SYS_RST, .AWVALID, .AWREADY,
    .WVALID, .WREADY, .BRESP, .BVALID, .BREADY, .ARVALID, .ARREADY,
    .RDATA, .RRESP, .RVALID, .RREADY, .WDT_RESET, .WDT_IRQ, .RESET_VECTOR);

// >>> verif/watchdog_timer_control_tb_top.sv
// Purpose: Directed bench for the watchdog control block
// Assumes: Shortened counts BASE 4 and tick divider 2
// Notes: AXI4-Lite master with ready signals held high
`timescale 1ns/1ps
module watchdog_timer_control_tb_top;
    localparam int BASE = 4;
    localparam int DIV = 2;
    logic clk = 1'b0, rst = 1'b1, fuse = 1'b0;
    logic [7:0] awaddr = 8'h00, araddr = 8'h00;
    logic awvalid = 1'b0, wvalid = 1'b0, arvalid = 1'b0;
    logic bready = 1'b1, rready = 1'b1;
    logic [31:0] wdata = 32'h0, rdata;
    logic [3:0] wstrb = 4'h1;
    logic awready, wready, bvalid, arready, rvalid, wdt_reset, wdt_irq;
    logic [1:0] bresp, rresp;
    logic [15:0] vec;
    int fail_count = 0, num_checks = 0, pulses = 0;
    wdtc_top #(.BASE_CYCLES(BASE), .TICK_DIV(DIV)) u_dut (
        .SYS_CLK(clk), .SYS_RST(rst), .SAFETY_LEVEL_FUSE(fuse),
        .AWADDR(awaddr), .AWVALID(awvalid), .AWREADY(awready),
        .WDATA(wdata), .WSTRB(wstrb), .WVALID(wvalid), .WREADY(wready),
        .BRESP(bresp), .BVALID(bvalid), .BREADY(bready),
        .ARADDR(araddr), .ARVALID(arvalid), .ARREADY(arready),
        .RDATA(rdata), .RRESP(rresp), .RVALID(rvalid), .RREADY(rready),
        .WDT_RESET(wdt_reset), .WDT_IRQ(wdt_irq), .RESET_VECTOR(vec));
    always #50 clk = ~clk;
    always @(posedge clk) if (wdt_reset === 1'b1) pulses++;
    task automatic end_sim();
        $display("checks %0d mismatches %0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d,
                      output logic [1:0] r);
        logic ao, wo;
        ao = 1'b1;
        wo = 1'b1;
        awaddr <= a;
        wdata <= {24'h0, d};
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        while (ao || wo) begin
            @(posedge clk);
            if (ao && awready === 1'b1) begin ao = 1'b0; awvalid <= 1'b0; end
            if (wo && wready === 1'b1) begin wo = 1'b0; wvalid <= 1'b0; end
        end
        do @(posedge clk); while (bvalid !== 1'b1);
        r = bresp;
    endtask
    task automatic w(input logic [7:0] a, input logic [7:0] d);
        logic [1:0] r;
        wr(a, d, r);
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] d,
                      output logic [1:0] r);
        araddr <= a;
        arvalid <= 1'b1;
        do @(posedge clk); while (arready !== 1'b1);
        arvalid <= 1'b0;
        do @(posedge clk); while (rvalid !== 1'b1);
        d = rdata;
        r = rresp;
    endtask
    task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] d;
        logic [1:0] r;
        rd(a, d, r);
        chk(d, exp);
    endtask
    task automatic rst_dut(input logic f);
        fuse <= f;
        rst <= 1'b1;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        repeat (4) @(posedge clk);
    endtask
    task automatic wait_expiry(output int n);
        n = 0;
        while (wdt_reset !== 1'b1) begin @(posedge clk); n++; end
    endtask
    task automatic t_regs();
        logic [31:0] d;
        logic [1:0] r;
        rst_dut(1'b0);
        rdc(wdtc_pkg::CTRL_OFF, 32'h0);
        chk(vec, 32'h0);
        rd(8'h14, d, r);
        chk(d, 32'h0);
        chk(r, wdtc_pkg::RESP_SLVERR);
        wr(8'h14, 8'h55, r);
        chk(r, wdtc_pkg::RESP_SLVERR);
        wstrb <= 4'h0;
        wr(wdtc_pkg::CTRL_OFF, 8'h08, r);
        chk(r, wdtc_pkg::RESP_OKAY);
        wstrb <= 4'h1;
        rdc(wdtc_pkg::CTRL_OFF, 32'h0);
        wr(wdtc_pkg::CTRL_OFF, 8'h2a, r);
        chk(r, wdtc_pkg::RESP_OKAY);
        rd(wdtc_pkg::CTRL_OFF, d, r);
        chk(d, 32'h2a);
        chk(r, wdtc_pkg::RESP_OKAY);
        $display("test regs done");
    endtask
    task automatic t_period(input logic [3:0] code);
        int n, e;
        rst_dut(1'b0);
        e = (BASE << (code > 9 ? 9 : code)) * DIV;
        w(wdtc_pkg::CTRL_OFF, {2'b00, code[3], 2'b01, code[2:0]});
        wait_expiry(n);
        chk(n + 3 >= e && n <= e + 2 * DIV + 3, 1);
        @(posedge clk);
        rdc(wdtc_pkg::RSTAT_OFF, 32'h08);
        $display("test period %0d done", code);
    endtask
    task automatic t_flag();
        int n, m;
        rst_dut(1'b0);
        w(wdtc_pkg::IMASK_OFF, 8'h01);
        w(wdtc_pkg::CTRL_OFF, 8'h0b);
        wait_expiry(n);
        repeat (3) @(posedge clk);
        chk(wdt_irq, 1);
        rdc(wdtc_pkg::ISTAT_OFF, 32'h01);
        repeat (2) @(posedge clk);
        chk(wdt_irq, 0);
        w(wdtc_pkg::CTRL_OFF, 8'h1b);
        w(wdtc_pkg::CTRL_OFF, 8'h03);
        rdc(wdtc_pkg::CTRL_OFF, 32'h0b);
        w(wdtc_pkg::RSTAT_OFF, 8'h00);
        rdc(wdtc_pkg::RSTAT_OFF, 32'h00);
        w(wdtc_pkg::CTRL_OFF, 8'h1b);
        w(wdtc_pkg::CTRL_OFF, 8'h03);
        rdc(wdtc_pkg::CTRL_OFF, 32'h03);
        rdc(wdtc_pkg::ISTAT_OFF, 32'h02);
        m = pulses;
        repeat (150) @(posedge clk);
        chk(pulses, m);
        $display("test flag done");
    endtask
    task automatic t_late();
        rst_dut(1'b0);
        w(wdtc_pkg::CTRL_OFF, 8'h0b);
        w(wdtc_pkg::CTRL_OFF, 8'h03);
        rdc(wdtc_pkg::CTRL_OFF, 32'h0b);
        w(wdtc_pkg::CTRL_OFF, 8'h1b);
        rdc(wdtc_pkg::CTRL_OFF, 32'h1b);
        repeat (8) @(posedge clk);
        rdc(wdtc_pkg::CTRL_OFF, 32'h0b);
        w(wdtc_pkg::CTRL_OFF, 8'h03);
        rdc(wdtc_pkg::CTRL_OFF, 32'h0b);
        $display("test late done");
    endtask
    task automatic t_restart();
        int n, m;
        rst_dut(1'b0);
        w(wdtc_pkg::CTRL_OFF, 8'h0b);
        m = pulses;
        repeat (6) begin
            repeat (30) @(posedge clk);
            w(wdtc_pkg::RESTART_OFF, 8'h00);
        end
        chk(pulses, m);
        wait_expiry(n);
        chk(n + 3 >= 32 * DIV && n <= 32 * DIV + 2 * DIV + 3, 1);
        $display("test restart done");
    endtask
    task automatic t_level2();
        rst_dut(1'b1);
        rdc(wdtc_pkg::CTRL_OFF, 32'h08);
        w(wdtc_pkg::CTRL_OFF, 8'h18);
        w(wdtc_pkg::CTRL_OFF, 8'h03);
        rdc(wdtc_pkg::CTRL_OFF, 32'h0b);
        w(wdtc_pkg::CTRL_OFF, 8'h01);
        rdc(wdtc_pkg::CTRL_OFF, 32'h0b);
        $display("test level2 done");
    endtask
    initial begin
        // Reset stays high into the first test's own reset
        repeat (18) @(posedge clk);
        t_regs();
        t_period(4'h0);
        t_period(4'h1);
        t_period(4'h9);
        t_period(4'ha);
        t_flag();
        t_late();
        t_restart();
        t_level2();
        end_sim();
    end
    initial begin
        #(100 * 40000);
        fail_count++;
        end_sim();
    end
endmodule
